/* amp_audio_path_config_regs.sv */
// Audio path configuration register bank of a mono headphone amplifier.
// Assumes an I2C slave on clk hands over byte accesses as one-cycle strobes
// and that the audio datapath supplies sample strobes on the same clock.
// Functional notes
// - Auto sleep after 2048 zero samples
// - Master sleep resets set, holds blocks idle
// - Bit clock rate field defaults automatic
// - Bit 7 selects pulse pair phase
// - Pulse filter strength, reset lowest filtering
// - Bit 3 selects rising or falling data
// - Two-bit pulse clock range select
// - Bit 0 selects serial or pulse input
// - Converter power level and bias, bias 11 reserved
// - Four-bit converter sample rate, reset 0101
// - Invert bit flips converter phase
// - Bit 6 enables high performance converter
// - Soft ramp unless immediate; zero cross option
// - Extra interpolation filtering when set
// - Gain bypass select, reset fixed 0 dB
// - High-pass cutoff codes, enable gates filter
// - Volume code, all ones mutes output
// - Clip level all ones disables clipping
// - Frame clock polarity, both polarities reset zero
// - Bit clock polarity picks capture edge
// - Data format sets frame-to-data delay
`timescale 1ns/1ps
`default_nettype none

module amp_audio_path_config_regs
    import amp_cfg_pkg::*;
#(
    parameter int ZERO_RUN = amp_cfg_pkg::ZERO_RUN_LEN   // Zero samples before auto sleep
) (
    input  wire logic                   clk,          // 100 MHz system clock
    input  wire logic                   rst_n,        // Synchronous reset, low active
    input  wire logic                   wr_stb,       // Register write strobe
    input  wire logic                   rd_stb,       // Register read strobe
    input  wire logic [7:0]             sub_addr,     // Register subaddress
    input  wire logic [7:0]             wr_data,      // Write data
    output logic      [7:0]             rd_data,      // Read data, registered
    output logic                        addr_ok,      // Subaddress is mapped
    input  wire logic                   sample_stb,   // One input sample arrived
    input  wire logic                   sample_zero,  // That sample is zero
    output amp_cfg_pkg::path_cfg_s      cfg,          // Field view of all registers
    output amp_cfg_pkg::path_ctrl_s     ctrl          // Derived controls
);
    import amp_cfg_pkg::*;

    localparam int ZW = $clog2(ZERO_RUN + 1);

    logic [7:0] power_q;
    logic [7:0] clk_rate_q;
    logic [7:0] pdm_cfg_q;
    logic [7:0] dac_rate_q;
    logic [7:0] dac_opt_q;
    logic [7:0] dac_hpf_q;
    logic [7:0] dac_volume_level_q;
    logic [7:0] dac_clip_q;
    logic [7:0] spt_set_q;
    logic [ZW-1:0] zero_cnt_q;
    logic          auto_slept_q;

    // Address decode
    wire hit_power    = (sub_addr == ADDR_POWER);
    wire hit_clk_rate = (sub_addr == ADDR_CLK_RATE);
    wire hit_pdm_cfg  = (sub_addr == ADDR_PDM_CFG);
    wire hit_dac_rate = (sub_addr == ADDR_DAC_RATE);
    wire hit_dac_opt  = (sub_addr == ADDR_DAC_OPT);
    wire hit_dac_hpf  = (sub_addr == ADDR_DAC_HPF);
    wire hit_dac_volume_level  = (sub_addr == ADDR_DAC_VOLUME_LEVEL);
    wire hit_dac_clip = (sub_addr == ADDR_DAC_CLIP);
    wire hit_spt_set  = (sub_addr == ADDR_SPT_SET);
    assign addr_ok = hit_power | hit_clk_rate | hit_pdm_cfg | hit_dac_rate | hit_dac_opt
                   | hit_dac_hpf | hit_dac_volume_level | hit_dac_clip | hit_spt_set;

    // Reserved bits are masked at the write so they can never read back set
    wire [7:0] power_d    = wr_data & MASK_POWER;
    wire [7:0] clk_rate_d = wr_data & MASK_CLK_RATE;
    wire [7:0] pdm_cfg_d  = wr_data & MASK_PDM_CFG;
    wire [7:0] dac_hpf_d  = wr_data & MASK_DAC_HPF;

    wire [7:0] rd_mux =
          hit_power    ? power_q
        : hit_clk_rate ? clk_rate_q
        : hit_pdm_cfg  ? pdm_cfg_q
        : hit_dac_rate ? dac_rate_q
        : hit_dac_opt  ? dac_opt_q
        : hit_dac_hpf  ? dac_hpf_q
        : hit_dac_volume_level  ? dac_volume_level_q
        : hit_dac_clip ? dac_clip_q
        : hit_spt_set  ? spt_set_q
        : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_q    <= RST_POWER;
            clk_rate_q <= RST_CLK_RATE;
            pdm_cfg_q  <= RST_PDM_CFG;
            dac_rate_q <= RST_DAC_RATE;
            dac_opt_q  <= RST_DAC_OPT;
            dac_hpf_q  <= RST_DAC_HPF;
            dac_volume_level_q  <= RST_DAC_VOLUME_LEVEL;
            dac_clip_q <= RST_DAC_CLIP;
            spt_set_q  <= RST_SPT_SET;
        end else if (wr_stb) begin
            if (hit_power)    power_q    <= power_d;
            if (hit_clk_rate) clk_rate_q <= clk_rate_d;
            if (hit_pdm_cfg)  pdm_cfg_q  <= pdm_cfg_d;
            if (hit_dac_rate) dac_rate_q <= wr_data;
            if (hit_dac_opt)  dac_opt_q  <= wr_data;
            if (hit_dac_hpf)  dac_hpf_q  <= dac_hpf_d;
            if (hit_dac_volume_level)  dac_volume_level_q  <= wr_data;
            if (hit_dac_clip) dac_clip_q <= wr_data;
            if (hit_spt_set)  spt_set_q  <= wr_data;
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_stb) begin
            rd_data <= rd_mux;
        end
    end

    // Field breakout
    assign cfg.limiter_enable        = power_q[POS_LIMITER_EN];
    assign cfg.auto_sleep_enable     = power_q[POS_AUTO_SLEEP];
    assign cfg.master_sleep          = power_q[POS_MASTER_SLEEP];
    assign cfg.bit_clock_rate        = clk_rate_q[4:0];
    assign cfg.pulse_pair_phase      = pdm_cfg_q[POS_PAIR_PHASE];
    assign cfg.pulse_input_filter    = pdm_cfg_q[POS_PULSE_INPUT_FILTER +: 2];
    assign cfg.pulse_edge_channel    = pdm_cfg_q[POS_EDGE_CHAN];
    assign cfg.pulse_clock_range     = pdm_cfg_q[POS_PDM_RANGE +: 2];
    assign cfg.pulse_input_select    = pdm_cfg_q[POS_INPUT_SEL];
    assign cfg.converter_bias        = dac_rate_q[POS_BIAS +: 2];
    assign cfg.converter_power_level = dac_rate_q[POS_PWR_LEVEL +: 2];
    assign cfg.converter_sample_rate = dac_rate_q[POS_SAMPLE_RATE +: 4];
    assign cfg.dac_invert            = dac_opt_q[POS_INVERT];
    assign cfg.converter_high_perf   = dac_opt_q[POS_HIGH_PERF];
    assign cfg.immediate_gain_change = dac_opt_q[POS_IMMEDIATE];
    assign cfg.gain_zero_cross       = dac_opt_q[POS_ZERO_CROSS];
    assign cfg.extra_interp_filter   = dac_opt_q[POS_EXTRA_FILT];
    assign cfg.gain_bypass_select    = dac_opt_q[POS_GAIN_BYPASS +: 2];
    assign cfg.dac_mute              = dac_opt_q[POS_MUTE];
    assign cfg.highpass_cutoff       = dac_hpf_q[POS_HPF_CUTOFF +: 4];
    assign cfg.highpass_enable       = dac_hpf_q[POS_HPF_EN];
    assign cfg.gain_level            = dac_volume_level_q;
    assign cfg.clip_level            = dac_clip_q;
    assign cfg.frame_clock_polarity  = spt_set_q[POS_FRAME_POL];
    assign cfg.bit_clock_polarity    = spt_set_q[POS_BIT_POL];
    assign cfg.slot_length           = spt_set_q[POS_SLOT_LEN +: 2];
    assign cfg.serial_format         = spt_set_q[POS_FORMAT +: 3];
    assign cfg.tdm_mode              = spt_set_q[POS_TDM_MODE];

    // Zero-run counter; a nonzero sample or disabling the feature restarts it
    wire zero_full = (zero_cnt_q == ZW'(ZERO_RUN));
    always_ff @(posedge clk) begin
        if (!rst_n || !cfg.auto_sleep_enable) begin
            zero_cnt_q   <= '0;
            auto_slept_q <= 1'b0;
        end else if (sample_stb) begin
            if (!sample_zero) begin
                zero_cnt_q   <= '0;
                auto_slept_q <= 1'b0;
            end else if (!zero_full) begin
                zero_cnt_q   <= zero_cnt_q + ZW'(1);
                auto_slept_q <= (zero_cnt_q == ZW'(ZERO_RUN - 1));
            end
        end
    end

    // Derived controls for the datapath
    // Gated by the enable so clearing it wakes the path in the same cycle
    assign ctrl.sleep        = cfg.master_sleep | (cfg.auto_sleep_enable & auto_slept_q);
    assign ctrl.hpf_active   = cfg.highpass_enable
                             & (cfg.highpass_cutoff >= HPF_FIRST_OK);
    assign ctrl.output_muted = cfg.dac_mute | (cfg.gain_level == VOL_MUTE_CODE);
    assign ctrl.clip_active  = (cfg.clip_level != CLIP_OFF_CODE);

    // Reserved slot code 11 falls back to the widest slot
    wire [5:0] slot_bclks_w = (cfg.slot_length == 2'h1) ? 6'd16
                            : (cfg.slot_length == 2'h2) ? 6'd24
                            : 6'd32;
    assign ctrl.slot_bclks  = slot_bclks_w;

    // Reserved format codes fall back to the two-channel delay
    wire [4:0] data_delay_w = (cfg.serial_format == 3'h1) ? 5'd0
                            : (cfg.serial_format == 3'h2) ? 5'd8
                            : (cfg.serial_format == 3'h3) ? 5'd12
                            : (cfg.serial_format == 3'h4) ? 5'd16
                            : 5'd1;
    assign ctrl.data_delay  = data_delay_w;

    // Every check runs on the system clock and stands down while reset is held
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_sleep_after_reset: assert property (
        $rose(rst_n)
        |-> ctrl.sleep)
        else $error("sleep not held after reset");

    chk_sleep_clear_write: assert property (
        (wr_stb && hit_power && !wr_data[POS_MASTER_SLEEP] && !wr_data[POS_AUTO_SLEEP])
        |=> !ctrl.sleep)
        else $error("master sleep not cleared");

    chk_auto_sleep_off: assert property (
        !cfg.auto_sleep_enable
        |-> ##1 !auto_slept_q)
        else $error("auto sleep while off");

    chk_auto_sleep_count: assert property (
        $rose(auto_slept_q)
        |-> $past(zero_cnt_q) == ZW'(ZERO_RUN - 1))
        else $error("auto sleep at wrong count");

    chk_reserved_zero: assert property (
        ((power_q & ~MASK_POWER) == 8'h00) && ((pdm_cfg_q & ~MASK_PDM_CFG) == 8'h00)
        && ((dac_hpf_q & ~MASK_DAC_HPF) == 8'h00) && (clk_rate_q[7:5] == 3'h0))
        else $error("reserved bit set");

    chk_unmapped_read: assert property (
        (rd_stb && !addr_ok)
        |=> rd_data == 8'h00)
        else $error("unmapped read nonzero");

    chk_ignored_write: assert property (
        (wr_stb && !addr_ok)
        |=> $stable({power_q, clk_rate_q, pdm_cfg_q, dac_rate_q, dac_opt_q, dac_hpf_q,
                     dac_volume_level_q, dac_clip_q, spt_set_q}))
        else $error("unmapped write changed a register");

    chk_mute_code: assert property (
        (cfg.gain_level == VOL_MUTE_CODE)
        |-> ctrl.output_muted)
        else $error("mute code not muting");

    chk_hpf_gate: assert property (
        ctrl.hpf_active
        |-> cfg.highpass_enable)
        else $error("filter on while disabled");

    chk_slot_len: assert property (
        (cfg.slot_length == 2'h1)
        |-> ctrl.slot_bclks == 6'd16)
        else $error("slot length wrong");

    chk_format_delay: assert property (
        (cfg.serial_format == 3'h4)
        |-> ctrl.data_delay == 5'd16)
        else $error("data delay wrong");

    chk_rate_store: assert property (
        (wr_stb && hit_clk_rate)
        |=> cfg.bit_clock_rate == $past(wr_data[4:0]))
        else $error("clock rate not stored");

    chk_pair_phase_store: assert property (
        (wr_stb && hit_pdm_cfg)
        |=> cfg.pulse_pair_phase == $past(wr_data[POS_PAIR_PHASE]))
        else $error("pair phase not stored");

    chk_filter_store: assert property (
        (wr_stb && hit_pdm_cfg)
        |=> cfg.pulse_input_filter == $past(wr_data[POS_PULSE_INPUT_FILTER +: 2]))
        else $error("pulse filter not stored");

    chk_edge_store: assert property (
        (wr_stb && hit_pdm_cfg)
        |=> cfg.pulse_edge_channel == $past(wr_data[POS_EDGE_CHAN]))
        else $error("edge channel not stored");

    chk_range_store: assert property (
        (wr_stb && hit_pdm_cfg)
        |=> cfg.pulse_clock_range == $past(wr_data[POS_PDM_RANGE +: 2]))
        else $error("clock range not stored");

    chk_input_store: assert property (
        (wr_stb && hit_pdm_cfg)
        |=> cfg.pulse_input_select == $past(wr_data[POS_INPUT_SEL]))
        else $error("input select not stored");

    chk_power_mode_store: assert property (
        (wr_stb && hit_dac_rate)
        |=> {cfg.converter_bias, cfg.converter_power_level} == $past(wr_data[7:4]))
        else $error("power mode not stored");

    chk_sample_rate_store: assert property (
        (wr_stb && hit_dac_rate)
        |=> cfg.converter_sample_rate == $past(wr_data[POS_SAMPLE_RATE +: 4]))
        else $error("sample rate not stored");

    chk_invert_store: assert property (
        (wr_stb && hit_dac_opt)
        |=> cfg.dac_invert == $past(wr_data[POS_INVERT]))
        else $error("invert not stored");

    chk_perf_store: assert property (
        (wr_stb && hit_dac_opt)
        |=> cfg.converter_high_perf == $past(wr_data[POS_HIGH_PERF]))
        else $error("high perf not stored");

    chk_ramp_store: assert property (
        (wr_stb && hit_dac_opt)
        |=> {cfg.immediate_gain_change, cfg.gain_zero_cross} == $past(wr_data[5:4]))
        else $error("ramp options not stored");

    chk_interp_store: assert property (
        (wr_stb && hit_dac_opt)
        |=> cfg.extra_interp_filter == $past(wr_data[POS_EXTRA_FILT]))
        else $error("extra filter not stored");

    chk_bypass_store: assert property (
        (wr_stb && hit_dac_opt)
        |=> cfg.gain_bypass_select == $past(wr_data[POS_GAIN_BYPASS +: 2]))
        else $error("gain bypass not stored");

    chk_volume_store: assert property (
        (wr_stb && hit_dac_volume_level)
        |=> cfg.gain_level == $past(wr_data))
        else $error("volume not stored");

    chk_clip_store: assert property (
        (wr_stb && hit_dac_clip)
        |=> cfg.clip_level == $past(wr_data))
        else $error("clip level not stored");

    chk_frame_pol_store: assert property (
        (wr_stb && hit_spt_set)
        |=> cfg.frame_clock_polarity == $past(wr_data[POS_FRAME_POL]))
        else $error("frame polarity not stored");

    chk_bit_pol_store: assert property (
        (wr_stb && hit_spt_set)
        |=> cfg.bit_clock_polarity == $past(wr_data[POS_BIT_POL]))
        else $error("bit polarity not stored");

endmodule : amp_audio_path_config_regs

`default_nettype wire

/* amp_audio_path_config_regs_test.sv */
// Self-checking bench for the audio path configuration bank.
// Assumes the host model drives strobes; the bench drives sample strobes.
`timescale 1ns/1ps
`default_nettype none

module amp_audio_path_config_regs_test;
    import amp_cfg_pkg::*;
    localparam int ZR = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sample_stb = 1'b0;
    logic        sample_zero = 1'b0;
    wire logic   wr_stb, rd_stb, addr_ok;
    wire logic [7:0] sub_addr, wr_data, rd_data;
    path_cfg_s   cfg;
    path_ctrl_s  ctrl;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [31:0] seed = 32'h1445;
    logic [7:0]  rv, ra, d;
    logic        ok;

    always #5 clk = ~clk;

    host_port_model u_host_port_model (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .sub_addr(sub_addr), .wr_data(wr_data), .rd_data(rd_data), .addr_ok(addr_ok));

    amp_audio_path_config_regs #(.ZERO_RUN(ZR)) u_amp_audio_path_config_regs (
        .clk(clk), .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .sub_addr(sub_addr),
        .wr_data(wr_data), .rd_data(rd_data), .addr_ok(addr_ok), .sample_stb(sample_stb),
        .sample_zero(sample_zero), .cfg(cfg), .ctrl(ctrl));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] rst_of(input logic [7:0] a);
        case (a)
            ADDR_POWER:    return RST_POWER;
            ADDR_CLK_RATE: return RST_CLK_RATE;
            ADDR_PDM_CFG:  return RST_PDM_CFG;
            ADDR_DAC_RATE: return RST_DAC_RATE;
            ADDR_DAC_OPT:  return RST_DAC_OPT;
            ADDR_DAC_HPF:  return RST_DAC_HPF;
            ADDR_DAC_VOLUME_LEVEL:  return RST_DAC_VOLUME_LEVEL;
            ADDR_DAC_CLIP: return RST_DAC_CLIP;
            ADDR_SPT_SET:  return RST_SPT_SET;
            default:       return 8'h00;
        endcase
    endfunction : rst_of

    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            ADDR_POWER:    return MASK_POWER;
            ADDR_CLK_RATE: return MASK_CLK_RATE;
            ADDR_PDM_CFG:  return MASK_PDM_CFG;
            ADDR_DAC_HPF:  return MASK_DAC_HPF;
            default:       return (a >= 8'h07 && a <= 8'h0c) ? MASK_FULL : 8'h00;
        endcase
    endfunction : mask_of

    // Field view rebuilt in register bit order
    function automatic logic [7:0] view_of(input logic [7:0] a);
        case (a)
            ADDR_POWER:    return {3'h0, cfg.limiter_enable, 2'h0, cfg.auto_sleep_enable,
                                   cfg.master_sleep};
            ADDR_CLK_RATE: return {3'h0, cfg.bit_clock_rate};
            ADDR_PDM_CFG:  return {cfg.pulse_pair_phase, 1'b0, cfg.pulse_input_filter,
                                   cfg.pulse_edge_channel, cfg.pulse_clock_range,
                                   cfg.pulse_input_select};
            ADDR_DAC_RATE: return {cfg.converter_bias, cfg.converter_power_level,
                                   cfg.converter_sample_rate};
            ADDR_DAC_OPT:  return {cfg.dac_invert, cfg.converter_high_perf,
                                   cfg.immediate_gain_change, cfg.gain_zero_cross,
                                   cfg.extra_interp_filter, cfg.gain_bypass_select, cfg.dac_mute};
            ADDR_DAC_HPF:  return {cfg.highpass_cutoff, 3'h0, cfg.highpass_enable};
            ADDR_DAC_VOLUME_LEVEL:  return cfg.gain_level;
            ADDR_DAC_CLIP: return cfg.clip_level;
            ADDR_SPT_SET:  return {cfg.frame_clock_polarity, cfg.bit_clock_polarity,
                                   cfg.slot_length, cfg.serial_format, cfg.tdm_mode};
            default:       return 8'h00;
        endcase
    endfunction : view_of

    function automatic logic [5:0] slot_exp(input logic [1:0] c);
        return (c == 2'h1) ? 6'h10 : ((c == 2'h2) ? 6'h18 : 6'h20);
    endfunction : slot_exp

    function automatic logic [4:0] delay_exp(input logic [2:0] f);
        case (f)
            3'h1:    return 5'h00;
            3'h2:    return 5'h08;
            3'h3:    return 5'h0c;
            3'h4:    return 5'h10;
            default: return 5'h01;
        endcase
    endfunction : delay_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Samples are counted per strobe, so idle cycles do not break a zero run
    task automatic send_samples(input int n, input logic z);
        repeat (n) begin
            @(posedge clk);
            sample_stb  <= 1'b1;
            sample_zero <= z;
        end
        @(posedge clk);
        sample_stb  <= 1'b0;
        sample_zero <= ~z;
        @(posedge clk);
        #1;
    endtask : send_samples

    initial begin
        #100000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(ctrl.sleep, 1'b1);
        for (int a = 3; a <= 14; a++) begin
            u_host_port_model.read_reg(8'(a), d, ok);
            check(d, rst_of(8'(a)));
            check(ok, a >= 4 && a <= 12);
        end
        repeat (60) begin
            u_host_port_model.gap_cycles = int'(xs() % 3);
            ra = 8'h04 + 8'(xs() % 10);
            rv = 8'(xs());
            u_host_port_model.write_reg(ra, rv);
            check(view_of(ra), rv & mask_of(ra));
            u_host_port_model.read_reg(ra, d, ok);
            check(d, rv & mask_of(ra));
        end
        u_host_port_model.gap_cycles = 0;
        for (int c = 0; c < 4; c++) begin
            u_host_port_model.write_reg(ADDR_SPT_SET, 8'(c << 4));
            check(ctrl.slot_bclks, slot_exp(2'(c)));
        end
        for (int f = 0; f < 8; f++) begin
            u_host_port_model.write_reg(ADDR_SPT_SET, 8'(f << 1));
            check(ctrl.data_delay, delay_exp(3'(f)));
        end
        for (int h = 0; h < 32; h++) begin
            u_host_port_model.write_reg(ADDR_DAC_HPF, {4'(h >> 1), 3'h0, 1'(h)});
            check(ctrl.hpf_active, h[0] && (h >> 1) >= 5);
        end
        u_host_port_model.write_reg(ADDR_DAC_OPT, 8'h12);
        u_host_port_model.write_reg(ADDR_DAC_VOLUME_LEVEL, 8'hfe);
        check(ctrl.output_muted, 1'b0);
        u_host_port_model.write_reg(ADDR_DAC_VOLUME_LEVEL, VOL_MUTE_CODE);
        check(ctrl.output_muted, 1'b1);
        u_host_port_model.write_reg(ADDR_DAC_CLIP, CLIP_OFF_CODE);
        check(ctrl.clip_active, 1'b0);
        u_host_port_model.write_reg(ADDR_DAC_CLIP, 8'hfe);
        check(ctrl.clip_active, 1'b1);
        u_host_port_model.write_reg(ADDR_DAC_CLIP, 8'h00);
        check(ctrl.clip_active, 1'b1);
        u_host_port_model.write_reg(ADDR_POWER, 8'h01);
        check(ctrl.sleep, 1'b1);
        u_host_port_model.write_reg(ADDR_POWER, 8'h00);
        check(ctrl.sleep, 1'b0);
        send_samples(ZR + 2, 1'b1);
        check(ctrl.sleep, 1'b0);
        u_host_port_model.write_reg(ADDR_POWER, 8'h02);
        send_samples(ZR - 1, 1'b1);
        send_samples(1, 1'b0);
        send_samples(ZR - 1, 1'b1);
        check(ctrl.sleep, 1'b0);
        send_samples(1, 1'b1);
        check(ctrl.sleep, 1'b1);
        u_host_port_model.write_reg(ADDR_POWER, 8'h00);
        check(ctrl.sleep, 1'b0);
        summarize();
    end
endmodule : amp_audio_path_config_regs_test

`default_nettype wire

/* amp_cfg_pkg.sv */
// Package for the headphone amplifier audio path configuration bank.
// Assumes an I2C slave elsewhere presents byte-wide register accesses.
package amp_cfg_pkg;

    // Register offsets (I2C subaddresses)
    localparam logic [7:0] ADDR_POWER     = 8'h04;
    localparam logic [7:0] ADDR_CLK_RATE  = 8'h05;
    localparam logic [7:0] ADDR_PDM_CFG   = 8'h06;
    localparam logic [7:0] ADDR_DAC_RATE  = 8'h07;
    localparam logic [7:0] ADDR_DAC_OPT   = 8'h08;
    localparam logic [7:0] ADDR_DAC_HPF   = 8'h09;
    localparam logic [7:0] ADDR_DAC_VOLUME_LEVEL   = 8'h0a;
    localparam logic [7:0] ADDR_DAC_CLIP  = 8'h0b;
    localparam logic [7:0] ADDR_SPT_SET   = 8'h0c;

    // Reset values
    localparam logic [7:0] RST_POWER      = 8'h01;
    localparam logic [7:0] RST_CLK_RATE   = 8'h00;
    localparam logic [7:0] RST_PDM_CFG    = 8'h20;
    localparam logic [7:0] RST_DAC_RATE   = 8'h15;
    localparam logic [7:0] RST_DAC_OPT    = 8'h13;
    localparam logic [7:0] RST_DAC_HPF    = 8'hd0;
    localparam logic [7:0] RST_DAC_VOLUME_LEVEL    = 8'h40;
    localparam logic [7:0] RST_DAC_CLIP   = 8'hff;
    localparam logic [7:0] RST_SPT_SET    = 8'h00;

    // Writable bit masks; other bits are reserved
    localparam logic [7:0] MASK_POWER     = 8'h13;
    localparam logic [7:0] MASK_CLK_RATE  = 8'h1f;
    localparam logic [7:0] MASK_PDM_CFG   = 8'hbf;
    localparam logic [7:0] MASK_DAC_HPF   = 8'hf1;
    localparam logic [7:0] MASK_FULL      = 8'hff;

    // Field positions
    localparam int POS_LIMITER_EN   = 4;
    localparam int POS_AUTO_SLEEP   = 1;
    localparam int POS_MASTER_SLEEP = 0;
    localparam int POS_PAIR_PHASE   = 7;
    localparam int POS_PULSE_INPUT_FILTER     = 4;
    localparam int POS_EDGE_CHAN    = 3;
    localparam int POS_PDM_RANGE    = 1;
    localparam int POS_INPUT_SEL    = 0;
    localparam int POS_BIAS         = 6;
    localparam int POS_PWR_LEVEL    = 4;
    localparam int POS_SAMPLE_RATE  = 0;
    localparam int POS_INVERT       = 7;
    localparam int POS_HIGH_PERF    = 6;
    localparam int POS_IMMEDIATE    = 5;
    localparam int POS_ZERO_CROSS   = 4;
    localparam int POS_EXTRA_FILT   = 3;
    localparam int POS_GAIN_BYPASS  = 1;
    localparam int POS_MUTE         = 0;
    localparam int POS_HPF_CUTOFF   = 4;
    localparam int POS_HPF_EN       = 0;
    localparam int POS_FRAME_POL    = 7;
    localparam int POS_BIT_POL      = 6;
    localparam int POS_SLOT_LEN     = 4;
    localparam int POS_FORMAT       = 1;
    localparam int POS_TDM_MODE     = 0;

    // Auto-sleep zero-sample count
    localparam int ZERO_RUN_LEN = 2048;

    // Code values with special meaning; the block acts on all but BIAS_RESERVED
    localparam logic [1:0] BIAS_RESERVED = 2'h3;
    localparam logic [7:0] VOL_MUTE_CODE = 8'hff;
    localparam logic [7:0] CLIP_OFF_CODE = 8'hff;
    localparam logic [3:0] HPF_FIRST_OK  = 4'h5;

    typedef struct packed {
        logic       limiter_enable;
        logic       auto_sleep_enable;
        logic       master_sleep;
        logic [4:0] bit_clock_rate;
        logic       pulse_pair_phase;
        logic [1:0] pulse_input_filter;
        logic       pulse_edge_channel;
        logic [1:0] pulse_clock_range;
        logic       pulse_input_select;
        logic [1:0] converter_bias;
        logic [1:0] converter_power_level;
        logic [3:0] converter_sample_rate;
        logic       dac_invert;
        logic       converter_high_perf;
        logic       immediate_gain_change;
        logic       gain_zero_cross;
        logic       extra_interp_filter;
        logic [1:0] gain_bypass_select;
        logic       dac_mute;
        logic [3:0] highpass_cutoff;
        logic       highpass_enable;
        logic [7:0] gain_level;
        logic [7:0] clip_level;
        logic       frame_clock_polarity;
        logic       bit_clock_polarity;
        logic [1:0] slot_length;
        logic [2:0] serial_format;
        logic       tdm_mode;
    } path_cfg_s;

    typedef struct packed {
        logic       sleep;          // Hold audio blocks in low power
        logic       hpf_active;     // High-pass filter running
        logic       output_muted;   // Mute by bit or by volume code
        logic       clip_active;    // Clipper engaged
        logic [5:0] slot_bclks;     // Bit clocks per slot
        logic [4:0] data_delay;     // Bit clocks from frame edge
    } path_ctrl_s;

endpackage : amp_cfg_pkg

/* host_port_model.sv */
// Host side of the register strobe port, standing in for the I2C slave.
// Assumes one clock domain; strobes last one cycle and change after edges.
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
    input  wire logic       clk,       // System clock
    output var  logic       wr_stb,    // Write strobe
    output var  logic       rd_stb,    // Read strobe
    output var  logic [7:0] sub_addr,  // Subaddress
    output var  logic [7:0] wr_data,   // Write byte
    input  wire logic [7:0] rd_data,   // Read byte
    input  wire logic       addr_ok    // Mapped subaddress
);
    int gap_cycles = 0;

    initial begin
        wr_stb   = 1'b0;
        rd_stb   = 1'b0;
        sub_addr = 8'h00;
        wr_data  = 8'h00;
    end

    // Idle lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        repeat (gap_cycles) @(posedge clk);
        @(posedge clk);
        wr_stb   <= 1'b1;
        sub_addr <= a;
        wr_data  <= d;
        @(posedge clk);
        wr_stb   <= 1'b0;
        sub_addr <= ~a;
        wr_data  <= ~d;
        #1;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        repeat (gap_cycles) @(posedge clk);
        @(posedge clk);
        rd_stb   <= 1'b1;
        sub_addr <= a;
        #1;
        ok = addr_ok;
        @(posedge clk);
        rd_stb   <= 1'b0;
        sub_addr <= ~a;
        #1;
        d = rd_data;
    endtask : read_reg
endmodule : host_port_model

`default_nettype wire
